// ---- rtl/cfg_port_defines.svh ----
// configuration port constants: mode codes, counts, reset values
// assumes inclusion by the port module only
//
// Function
// (RL1) parallel mode loads bytes on eight data pins
// (RL2) serial modes load through data bit zero
// (RL3) parallel access only while chip select low
// (RL4) write enable low marks a write transfer
// (RL5) busy output paces host parallel writes
// (RL6) serial modes forward data to next device
// (RL7) init pin low while memory clears
// (RL8) external init low postpones configuration start
// (RL9) init pin low reports data error
// (RL10) master drives configuration clock, slave receives
// (RL11) program reset low resets configuration asynchronously
// (RL12) done pin signals configuration finished
// (RL13) external done low delays start-up
// (RL14) pull-up enable turns on I/O pull-ups
// (RL15) power-down pin must never be driven low
// (RL16) byte taken: select, write low, not busy
`ifndef CFG_PORT_DEFINES_SVH
`define CFG_PORT_DEFINES_SVH

// -----------------------------------------------------------------
// mode select codes
// -----------------------------------------------------------------
`define MODE_MASTER_SERIAL 3'h0
`define MODE_MASTER_PAR    3'h3
`define MODE_SLAVE_PAR     3'h6
`define MODE_SLAVE_SERIAL  3'h7

// -----------------------------------------------------------------
// counts and reset values
// -----------------------------------------------------------------
`define CLEAR_CYCLES 16'h0040
`define CONFIG_CLOCK_DIV     8'h04
`define START_SETTLE 16'h0003
`define FIFO_DEPTH   4
`define RST_SYNC     2'h3

`endif

// ---- rtl/cfg_port_pkg.sv ----
// types shared by the configuration port
// assumes nothing beyond the defines header
package cfg_port_pkg;

  typedef enum logic [2:0] {
    ST_CLEAR   = 3'b000,
    ST_WAIT    = 3'b001,
    ST_LOAD    = 3'b010,
    ST_STARTUP = 3'b011,
    ST_USER    = 3'b100,
    ST_ERROR   = 3'b101
  } cfg_state_e;

  typedef struct packed {
    logic       serial;
    logic [7:0] data;
  } cfg_word_s;

endpackage

// ---- rtl/cfg_port.sv ----
// configuration port: pin capture on the link clock, handshake crossing,
// word FIFO and loader sequencing on mclk
// assumes open-drain pins are resolved outside from the enables and that in
// master modes the driven clock is looped back on config_clock
`timescale 1ns/1ns
`include "cfg_port_defines.svh"

// -----------------------------------------------------------------
// word FIFO
// -----------------------------------------------------------------
module cfg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= inc(wr_r);
      if (pop) rd_r <= inc(rd_r);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// -----------------------------------------------------------------
// configuration port top
// -----------------------------------------------------------------
module cfg_port #(
  parameter logic [15:0] CLEAR_CYCLES = `CLEAR_CYCLES,
  parameter logic [7:0]  CONFIG_CLOCK_DIV     = `CONFIG_CLOCK_DIV,
  parameter int          FIFO_DEPTH   = `FIFO_DEPTH
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   config_clock,
  output logic                        config_clock_out,
  output logic                        config_clock_oe,
  input  wire logic                   program_reset_n,
  input  wire logic [2:0]             config_mode_select,
  input  wire logic                   cfg_pullup_enable,
  input  wire logic                   done_wait_en,
  input  wire logic                   port_keep,
  input  wire logic [7:0]             config_data_in,
  input  wire logic                   chip_select_n,
  input  wire logic                   config_write_n,
  output logic                        busy_dout,
  input  wire logic                   init_in,
  output logic                        init_out,
  output logic                        init_oe,
  input  wire logic                   done_in,
  output logic                        done_out,
  output logic                        done_oe,
  output cfg_port_pkg::cfg_word_s     cfg_word,
  output logic                        cfg_valid,
  input  wire logic                   cfg_ready,
  input  wire logic                   load_done,
  input  wire logic                   data_error,
  output logic                        io_pullup_en,
  output logic                        config_port_active,
  output logic                        user_mode
);

  // -----------------------------------------------------------------
  // reset synchronisers, program pin acts asynchronously
  // -----------------------------------------------------------------
  wire       async_rst = rst || !program_reset_n; // RL11
  logic [1:0] crst_r;
  logic [1:0] lrst_r;
  wire       core_rst = crst_r[1];
  wire       link_rst = lrst_r[1];

  always_ff @(posedge mclk or posedge async_rst) begin
    if (async_rst) crst_r <= `RST_SYNC; // RL11
    else crst_r <= {crst_r[0], 1'b0};
  end

  always_ff @(posedge config_clock or posedge async_rst) begin
    if (async_rst) lrst_r <= `RST_SYNC; // RL11
    else lrst_r <= {lrst_r[0], 1'b0};
  end

  // -----------------------------------------------------------------
  // pin synchronisers on mclk
  // -----------------------------------------------------------------
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {config_mode_select, cfg_pullup_enable, done_wait_en, init_in, done_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire [2:0] mode_s   = pin_s2_r[6:4];
  wire       pullup_s = pin_s2_r[3];
  wire       dwait_s  = pin_s2_r[2];
  wire       init_s   = pin_s2_r[1];
  wire       done_s   = pin_s2_r[0];

  logic keep_s1_r;
  logic keep_s2_r;
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      keep_s1_r <= 1'b0;
      keep_s2_r <= 1'b0;
    end else begin
      keep_s1_r <= port_keep;
      keep_s2_r <= keep_s1_r;
    end
  end

  // -----------------------------------------------------------------
  // loader sequence
  // -----------------------------------------------------------------
  cfg_port_pkg::cfg_state_e st_r;
  cfg_port_pkg::cfg_state_e st_nxt;
  logic [15:0] cnt_r;
  logic [2:0]  mode_r;

  wire load_st = (st_r == cfg_port_pkg::ST_LOAD);
  wire par     = (mode_r == `MODE_MASTER_PAR) || (mode_r == `MODE_SLAVE_PAR);
  wire master  = (mode_r == `MODE_MASTER_PAR) || (mode_r == `MODE_MASTER_SERIAL);
  wire start_ok = !dwait_s || done_s; // RL13

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      cfg_port_pkg::ST_CLEAR: begin
        if (cnt_r == CLEAR_CYCLES - 16'h0001) st_nxt = cfg_port_pkg::ST_WAIT;
      end
      cfg_port_pkg::ST_WAIT: begin
        if (init_s) st_nxt = cfg_port_pkg::ST_LOAD; // RL8
      end
      cfg_port_pkg::ST_LOAD: begin
        if (data_error) st_nxt = cfg_port_pkg::ST_ERROR; // RL9
        else if (load_done) st_nxt = cfg_port_pkg::ST_STARTUP;
      end
      cfg_port_pkg::ST_STARTUP: begin
        if (cnt_r >= `START_SETTLE && start_ok) st_nxt = cfg_port_pkg::ST_USER; // RL13
      end
      cfg_port_pkg::ST_USER: st_nxt = cfg_port_pkg::ST_USER;
      cfg_port_pkg::ST_ERROR: st_nxt = cfg_port_pkg::ST_ERROR;
      default: st_nxt = cfg_port_pkg::ST_CLEAR;
    endcase
  end

  wire nxt_user  = (st_nxt == cfg_port_pkg::ST_USER);
  wire nxt_init  = (st_nxt == cfg_port_pkg::ST_CLEAR) || (st_nxt == cfg_port_pkg::ST_ERROR);
  wire nxt_dlow  = (st_nxt != cfg_port_pkg::ST_USER) && (st_nxt != cfg_port_pkg::ST_STARTUP);
  wire nxt_port  = !nxt_user || (keep_s2_r && par);

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      st_r   <= cfg_port_pkg::ST_CLEAR;
      cnt_r  <= '0;
      mode_r <= `MODE_SLAVE_SERIAL;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 16'h0000 : cnt_r + 16'h0001;
      if (st_r == cfg_port_pkg::ST_WAIT) mode_r <= mode_s;
    end
  end

  // -----------------------------------------------------------------
  // status pins and outputs
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      init_oe            <= 1'b1;
      init_out           <= 1'b0;
      done_oe            <= 1'b1;
      done_out           <= 1'b0;
      user_mode          <= 1'b0;
      io_pullup_en       <= 1'b0;
      config_port_active <= 1'b1;
    end else begin
      init_oe            <= nxt_init; // RL7
      init_out           <= 1'b0;
      done_oe            <= nxt_dlow; // RL12
      done_out           <= 1'b0;
      user_mode          <= nxt_user;
      io_pullup_en       <= pullup_s && !nxt_user; // RL14
      config_port_active <= nxt_port; // RL1
    end
  end

  // -----------------------------------------------------------------
  // master clock divider
  // -----------------------------------------------------------------
  logic [7:0] div_r;
  wire        run_clk = master && load_st;

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      div_r            <= '0;
      config_clock_out <= 1'b0;
      config_clock_oe  <= 1'b0;
    end else begin
      config_clock_oe <= run_clk; // RL10
      if (!run_clk || div_r == CONFIG_CLOCK_DIV - 8'h01) div_r <= '0;
      else div_r <= div_r + 8'h01;
      if (run_clk && div_r == CONFIG_CLOCK_DIV - 8'h01) config_clock_out <= !config_clock_out; // RL10
    end
  end

  // -----------------------------------------------------------------
  // link side on the configuration clock
  // -----------------------------------------------------------------
  logic [1:0] lv_s1_r;
  logic [1:0] lv_s2_r;
  logic       ack_s1_r;
  logic       ack_s2_r;
  logic       req_r;
  logic [7:0] word_r;
  logic       wser_r;
  logic [6:0] shift_r;
  logic [2:0] bit_r;
  logic       ack_r;

  wire l_load = lv_s2_r[1];
  wire l_par  = lv_s2_r[0];
  wire pend   = req_r ^ ack_s2_r;
  wire par_wr = !chip_select_n && !config_write_n; // RL3 RL4
  wire cap    = l_load && (l_par ? (par_wr && !pend) : (bit_r == 3'h7)); // RL16
  wire req_n  = req_r ^ cap;
  wire busy_n = !l_load || (req_n ^ ack_s2_r); // RL5

  always_ff @(posedge config_clock or posedge link_rst) begin
    if (link_rst) begin
      lv_s1_r   <= '0;
      lv_s2_r   <= '0;
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
      req_r     <= 1'b0;
      word_r    <= '0;
      wser_r    <= 1'b0;
      shift_r   <= '0;
      bit_r     <= '0;
      busy_dout <= 1'b1;
    end else begin
      lv_s1_r  <= {load_st, par};
      lv_s2_r  <= lv_s1_r;
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
      req_r    <= req_n;
      if (cap) begin
        word_r <= l_par ? config_data_in : {shift_r, config_data_in[0]}; // RL1 RL2
        wser_r <= !l_par;
      end
      if (l_load && !l_par) begin
        shift_r <= {shift_r[5:0], config_data_in[0]}; // RL2
        bit_r   <= bit_r + 3'h1;
      end else begin
        bit_r <= '0;
      end
      // busy stays high until the load level has crossed, whatever the mode
      busy_dout <= (l_par || !l_load) ? busy_n : config_data_in[0]; // RL5 RL6
    end
  end

  // -----------------------------------------------------------------
  // handshake into mclk, FIFO and output stage
  // -----------------------------------------------------------------
  logic req_s1_r;
  logic req_s2_r;
  logic f_in_rdy;
  logic f_out_vld;
  cfg_port_pkg::cfg_word_s f_in;
  cfg_port_pkg::cfg_word_s f_out;

  wire new_req = req_s2_r ^ ack_r;
  wire f_push  = new_req && load_st;
  wire out_take = !cfg_valid || cfg_ready;

  assign f_in.data   = word_r;
  assign f_in.serial = wser_r;

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ack_r    <= 1'b0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      if (new_req && (!load_st || f_in_rdy)) ack_r <= req_s2_r; // RL5
    end
  end

  cfg_fifo #(
    .WIDTH ($bits(cfg_port_pkg::cfg_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst       (core_rst),
    .in_data   (f_in),
    .in_valid  (f_push),
    .in_ready  (f_in_rdy),
    .out_data  (f_out),
    .out_valid (f_out_vld),
    .out_ready (out_take)
  );

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      cfg_valid <= 1'b0;
      cfg_word  <= '0;
    end else if (out_take) begin
      cfg_valid <= f_out_vld;
      if (f_out_vld) cfg_word <= f_out;
    end
  end

endmodule

// ---- bench/cfg_port_checker.sv ----
// assertions on the configuration port outputs
// assumes it is bound into cfg_port, pins resolved by the bench
`timescale 1ns/1ns
module cfg_port_checker (
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire logic                    config_clock,
  input wire logic                    config_clock_oe,
  input wire logic                    program_reset_n,
  input wire logic [2:0]              config_mode_select,
  input wire logic                    chip_select_n,
  input wire logic                    config_write_n,
  input wire logic                    busy_dout,
  input wire logic                    init_oe,
  input wire logic                    done_oe,
  input wire cfg_port_pkg::cfg_word_s cfg_word,
  input wire logic                    cfg_valid,
  input wire logic                    cfg_ready,
  input wire logic                    io_pullup_en,
  input wire logic                    config_port_active,
  input wire logic                    user_mode
);
  wire any_rst = rst || !program_reset_n;
  // ------------------------------------------------------------
  // output relations
  // ------------------------------------------------------------
  reset_out_a: assert property (@(posedge mclk) disable iff (any_rst)
    $fell(any_rst) |-> init_oe && done_oe && !user_mode && !cfg_valid) else $error("reset state");
  clear_hold_a: assert property (@(posedge mclk) disable iff (any_rst)
    $fell(any_rst) |-> init_oe [*8]) else $error("init released early");
  err_sticky_a: assert property (@(posedge mclk) disable iff (any_rst)
    $rose(init_oe) |=> init_oe [*8]) else $error("error not held");
  user_release_a: assert property (@(posedge mclk) disable iff (any_rst)
    user_mode |-> !init_oe && !done_oe) else $error("lines held in user mode");
  pullup_off_a: assert property (@(posedge mclk) disable iff (any_rst)
    io_pullup_en |-> !user_mode && config_port_active) else $error("pull-ups outside load");
  hold_word_a: assert property (@(posedge mclk) disable iff (any_rst)
    cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_word)) else $error("word dropped");
  word_kind_a: assert property (@(posedge mclk) disable iff (any_rst)
    cfg_valid |-> cfg_word.serial == !(config_mode_select inside {3'h3, 3'h6}))
    else $error("word kind");
  clk_drive_a: assert property (@(posedge mclk) disable iff (any_rst)
    config_clock_oe |-> config_mode_select inside {3'h0, 3'h3} && !user_mode)
    else $error("clock driven in slave mode");
  busy_take_a: assert property (@(posedge config_clock) disable iff (any_rst)
    config_mode_select == 3'h6 && !chip_select_n && !config_write_n && !busy_dout
    |=> busy_dout) else $error("busy not raised");
endmodule

bind cfg_port cfg_port_checker i_chk (.mclk, .rst, .config_clock, .config_clock_oe,
  .program_reset_n, .config_mode_select, .chip_select_n, .config_write_n, .busy_dout,
  .init_oe, .done_oe, .cfg_word, .cfg_valid, .cfg_ready, .io_pullup_en,
  .config_port_active, .user_mode);

// ---- bench/cfg_host.sv ----
// configuration host model: link clock within frames, data pins, line holds
// assumes the bench resolves the open-drain init and done lines
`timescale 1ns/1ns
module cfg_host (
  output logic       lclk,
  output logic [7:0] data,
  output logic       cs_n,
  output logic       we_n,
  output logic       init_low,
  output logic       done_low,
  output logic       power_down_n,
  input  wire logic  busy
);
  assign power_down_n = 1'b1;
  initial begin
    lclk = 1'b0;
    data = 8'h00;
    cs_n = 1'b1;
    we_n = 1'b1;
    init_low = 1'b0;
    done_low = 1'b0;
  end
  // ------------------------------------------------------------
  // transfers
  // ------------------------------------------------------------
  // one clock period; the clock rests low between frames
  task automatic tick();
    #7 lclk = 1'b1;
    #7 lclk = 1'b0;
    #1;
  endtask
  // write paced by busy; ok stays low when busy never drops
  task automatic put(input logic [7:0] b, input logic sel, input logic wr, output logic ok);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      tick();
      n++;
    end
    ok = (busy === 1'b0);
    if (ok) begin
      data = b;
      cs_n = !sel;
      we_n = !wr;
      tick();
      cs_n = 1'b1;
      we_n = 1'b1;
      data = ~b;
      // one idle edge keeps two writes apart
      tick();
    end
  endtask
  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      data[0] = b[i];
      tick();
    end
  endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the configuration port
// assumes the host model and the bound checker are compiled before it
`timescale 1ns/1ns
module tb_top;
  logic                    mclk, rst, program_reset_n, cfg_pullup_enable, done_wait_en, ok;
  logic                    port_keep, cfg_ready, load_done, data_error, rnd_rdy, fwd, fbit;
  logic                    chip_select_n, config_write_n, busy_dout, config_clock_out;
  logic                    config_clock_oe, init_out, init_oe, done_out, done_oe, lclk;
  logic                    cfg_valid, io_pullup_en, config_port_active, user_mode;
  logic                    init_low, done_low;
  logic [2:0]              config_mode_select;
  logic [7:0]              config_data_in, b;
  cfg_port_pkg::cfg_word_s cfg_word;
  cfg_port_pkg::cfg_word_s exp_q[$];
  int                      err_count = 0;
  int                      checks = 0;
  int                      cyc = 0;
  int                      n;
  wire                     config_clock = config_clock_oe ? config_clock_out : lclk;
  wire                     init_in = !(init_oe || init_low);
  wire                     done_in = !(done_oe || done_low);

  initial begin
    mclk = 1'b0;
    {rst, program_reset_n, cfg_pullup_enable, done_wait_en, cfg_ready} = 5'h1F;
    {port_keep, load_done, data_error, rnd_rdy, fwd} = 5'h00;
    config_mode_select = 3'h6;
  end
  always #4 mclk = ~mclk;

  cfg_port #(.CLEAR_CYCLES(16'h0008)) i_dut (.mclk, .rst, .config_clock, .config_clock_out,
    .config_clock_oe, .program_reset_n, .config_mode_select, .cfg_pullup_enable,
    .done_wait_en, .port_keep, .config_data_in, .chip_select_n, .config_write_n, .busy_dout,
    .init_in, .init_out, .init_oe, .done_in, .done_out, .done_oe, .cfg_word, .cfg_valid,
    .cfg_ready, .load_done, .data_error, .io_pullup_en, .config_port_active, .user_mode);
  cfg_host i_host (.lclk, .data(config_data_in), .cs_n(chip_select_n),
    .we_n(config_write_n), .init_low, .done_low, .power_down_n(), .busy(busy_dout));

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rnd_rdy) cfg_ready <= 1'($urandom);
    if (cfg_valid && cfg_ready) begin
      chk(exp_q.size() > 0, 1'b1);
      if (exp_q.size() > 0) chk(cfg_word, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // forwarded serial bit follows the data pin by one edge
  always @(posedge lclk) begin
    fbit = config_data_in[0];
    #1;
    if (fwd) chk(busy_dout, fbit);
  end
  task automatic start(input logic [2:0] m);
    @(posedge mclk);
    config_mode_select <= m;
    {load_done, data_error, rst} <= 3'h1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (n = 0; init_oe !== 1'b0 && n < 40; n++) @(posedge mclk);
    chk(n >= 8 && n <= 14, 1'b1);
  endtask
  task automatic wait_q();
    repeat (300) if (exp_q.size() > 0) @(posedge mclk);
    chk(9'(exp_q.size()), 9'h000);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    n = $urandom(32'h71504DF8);
    #1;
    i_host.init_low = 1'b1;
    start(3'h6);
    i_host.put(8'h5A, 1'b1, 1'b1, ok);
    chk(ok, 1'b0);
    chk(done_oe, 1'b1);
    i_host.init_low = 1'b0;
    rnd_rdy = 1'b1;
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      exp_q.push_back({1'b0, b});
      i_host.put(b, 1'b1, 1'b1, ok);
      chk(ok, 1'b1);
    end
    chk(io_pullup_en, 1'b1);
    i_host.put(8'h3C, 1'b0, 1'b1, ok);
    i_host.put(8'hC3, 1'b1, 1'b0, ok);
    wait_q();
    rnd_rdy = 1'b0;
    @(posedge mclk);
    cfg_ready <= 1'b1;
    repeat (40) @(posedge mclk);
    cfg_ready <= 1'b0;
    for (n = 0, ok = 1'b1; ok && n < 12; n += ok) begin
      b = 8'($urandom);
      i_host.put(b, 1'b1, 1'b1, ok);
      if (ok) exp_q.push_back({1'b0, b});
    end
    chk(n >= 4 && n < 12, 1'b1);
    @(posedge mclk);
    cfg_ready <= 1'b1;
    wait_q();
    i_host.done_low = 1'b1;
    load_done <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(user_mode, 1'b0);
    chk(done_oe, 1'b0);
    i_host.done_low = 1'b0;
    for (n = 0; user_mode !== 1'b1 && n < 12; n++) @(posedge mclk);
    chk(user_mode, 1'b1);
    chk(io_pullup_en, 1'b0);
    chk(config_port_active, 1'b0);
    start(3'h7);
    repeat (8) @(posedge mclk);
    // two edges leave link reset, two more carry the load level across
    repeat (4) i_host.tick();
    fwd = 1'b1;
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_q.push_back({1'b1, b});
      i_host.shift(b);
    end
    fwd = 1'b0;
    wait_q();
    data_error <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(init_oe, 1'b1);
    chk({init_out, done_out}, 9'h000);
    start(3'h3);
    for (n = 0; config_clock_oe !== 1'b1 && n < 20; n++) @(posedge mclk);
    chk(config_clock_oe, 1'b1);
    ok = config_clock_out;
    repeat (4) @(posedge mclk);
    chk(config_clock_out, !ok);
    program_reset_n <= 1'b0;
    #1;
    chk(config_clock_oe, 1'b0);
    chk(init_oe, 1'b1);
    @(posedge mclk);
    program_reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    test_done();
  end
endmodule
